/* File: hdl/uoe_consts.svh */
/*
  Offsets, field positions, reset values and sizes of the USB OTG
  event flag and endpoint FIFO data port block.
  Assumes an APB slave with 32-bit data and one word per register.
*/
// Notes on behaviour
// - Supply drop in session sets bit 23
// - Session request signalling sets bit 22
// - Host mode: peripheral detach sets bit 21
// - Peripheral mode: session end sets bit 21
// - Host mode: peripheral attach sets bit 20
// - Suspend interrupt only while enable set
// - Data port write pushes transmit queue
// - Data port read pops receive queue
`ifndef UOE_CONSTS_SVH
`define UOE_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define UOE_OFS_STATUS 12'h000
`define UOE_OFS_ENABLE 12'h004
`define UOE_OFS_CTRL 12'h008
`define UOE_OFS_FIFO_BASE 12'h020
`define UOE_OFS_FIFO_LAST 12'h03C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define UOE_BIT_SUPPLY_ERR 23
`define UOE_BIT_SESS_REQ 22
`define UOE_BIT_DETACH 21
`define UOE_BIT_ATTACH 20
`define UOE_BIT_SUSPEND 24
`define UOE_BIT_HOST_MODE 0
`define UOE_EVENT_MASK 32'h01F00000

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define UOE_RST_WORD 32'h00000000
`define UOE_NUM_EP 8
`define UOE_QDEPTH 8

`endif

/* File: hdl/uoe_pkg.sv */
/*
  Types of the USB OTG event flag and FIFO data port block.
  Assumes the constants header is included by users as needed.
*/
package uoe_pkg;

  // Link-side event pulses, one cycle each
  typedef struct packed {
    logic suspend;
    logic supply_low;
    logic session_request;
    logic detach;
    logic attach;
  } uoe_link_ev_s;

  // Data handed between block and packet engine
  typedef struct packed {
    logic [2:0] ep;
    logic [31:0] data;
  } uoe_word_s;

  typedef enum logic [0:0] {
    UOE_IDLE = 1'b0,
    UOE_DONE = 1'b1
  } uoe_apb_e;

endpackage

/* File: hdl/uoe_event_fifo.sv */
/*
  USB OTG event flags, suspend interrupt enable and per-endpoint FIFO
  data ports behind an APB slave.
  Assumes link events come from another domain and pass a two-flop
  synchroniser here; engine-side queue ports share pclk.
*/
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "uoe_consts.svh"

module uoe_event_fifo
  import uoe_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link status and events (asynchronous levels)
  input wire logic vbus_valid,
  input wire logic session_active,
  input wire logic srp_seen,
  input wire logic dev_present,
  input wire logic suspend_seen,
  // Packet engine: transmit drain
  output uoe_word_s tx_word,
  output logic tx_valid,
  input wire logic tx_ready,
  // Packet engine: receive fill
  input wire uoe_word_s rx_word,
  input wire logic rx_valid,
  output logic rx_ready,
  // Mode and interrupt
  output logic host_mode,
  output logic irq
);

  localparam int NE = `UOE_NUM_EP;
  localparam int QD = `UOE_QDEPTH;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sync1, sync2, prev;
  logic [4:0] next_sync1, next_sync2, next_prev;
  logic vb_ok, sess, srp, pres, susp;

  always_comb begin
    next_sync1 = {suspend_seen, dev_present, srp_seen, session_active, vbus_valid};
    next_sync2 = sync1;
    next_prev = sync2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
      prev <= 5'h00;
    end else begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
      prev <= next_prev;
    end
  end

  assign {susp, pres, srp, sess, vb_ok} = sync2;

  // Edge events derived from synchronised levels only
  uoe_link_ev_s ev;
  always_comb begin
    ev.supply_low = sess && !vb_ok && prev[0];
    ev.session_request = srp && !prev[2];
    ev.detach = host_mode ? (!pres && prev[3])
                          : (!sess && prev[1]);
    ev.attach = host_mode && pres && !prev[3];
    ev.suspend = susp && !prev[4];
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  function automatic logic is_fifo(input logic [11:0] a);
    is_fifo = (a >= `UOE_OFS_FIFO_BASE) && (a <= `UOE_OFS_FIFO_LAST) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [2:0] ep_of(input logic [11:0] a);
    logic [11:0] d;
    d = a - `UOE_OFS_FIFO_BASE;
    ep_of = d[4:2];
  endfunction

  logic acc, wr, rd, fifo_hit, known;
  logic [2:0] ep_sel;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign fifo_hit = is_fifo(paddr);
  assign ep_sel = ep_of(paddr);
  assign known = fifo_hit || paddr == `UOE_OFS_STATUS || paddr == `UOE_OFS_ENABLE
                 || paddr == `UOE_OFS_CTRL;
  assign pready = 1'b1;

  // ----------------------------------------------------------------
  // Status, enable and control registers
  // ----------------------------------------------------------------
  logic [31:0] status, enable;
  logic [31:0] next_status, next_enable;
  logic ctrl_host, next_ctrl_host;
  logic [31:0] set_bits;

  always_comb begin
    set_bits = `UOE_RST_WORD;
    set_bits[`UOE_BIT_SUPPLY_ERR] = ev.supply_low;
    set_bits[`UOE_BIT_SESS_REQ] = ev.session_request;
    set_bits[`UOE_BIT_DETACH] = ev.detach;
    set_bits[`UOE_BIT_ATTACH] = ev.attach;
    set_bits[`UOE_BIT_SUSPEND] = ev.suspend;
    next_status = status;
    next_enable = enable;
    next_ctrl_host = ctrl_host;
    // Write-one-to-clear, but a same-cycle event wins
    if (wr && paddr == `UOE_OFS_STATUS) begin
      next_status = status & ~pwdata;
    end
    next_status = (next_status | set_bits) & `UOE_EVENT_MASK;
    if (wr && paddr == `UOE_OFS_ENABLE) begin
      next_enable = pwdata & `UOE_EVENT_MASK;
    end
    if (wr && paddr == `UOE_OFS_CTRL) begin
      next_ctrl_host = pwdata[`UOE_BIT_HOST_MODE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= `UOE_RST_WORD;
      enable <= `UOE_RST_WORD;
      ctrl_host <= 1'b0;
    end else begin
      status <= next_status;
      enable <= next_enable;
      ctrl_host <= next_ctrl_host;
    end
  end

  assign host_mode = ctrl_host;
  // Suspend bit gated by its enable like every flag
  assign irq = |(status & enable);

  // ----------------------------------------------------------------
  // Per-endpoint queues
  // ----------------------------------------------------------------
  logic [31:0] txm [NE][QD];
  logic [31:0] rxm [NE][QD];
  logic [3:0] tx_cnt [NE];
  logic [3:0] rx_cnt [NE];
  logic [2:0] tx_wp [NE], tx_rp [NE], rx_wp [NE], rx_rp [NE];
  logic [2:0] drain_ep, next_drain_ep;
  logic [NE-1:0] tx_push, tx_pop, rx_push, rx_pop;

  assign tx_valid = tx_cnt[drain_ep] != 4'h0;
  assign tx_word.ep = drain_ep;
  assign tx_word.data = txm[drain_ep][tx_rp[drain_ep]];
  assign rx_ready = rx_cnt[rx_word.ep] != 4'(QD);

  // Round-robin: move on when current endpoint is empty
  always_comb begin
    next_drain_ep = drain_ep;
    if (!tx_valid) begin
      next_drain_ep = drain_ep + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drain_ep <= 3'h0;
    end else begin
      drain_ep <= next_drain_ep;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NE; g++) begin : g_ep
      // Write to a full queue is dropped and flagged by pslverr
      assign tx_push[g] = wr && fifo_hit && ep_sel == 3'(g) && tx_cnt[g] != 4'(QD);
      assign tx_pop[g] = tx_valid && tx_ready && drain_ep == 3'(g);
      assign rx_push[g] = rx_valid && rx_ready && rx_word.ep == 3'(g);
      assign rx_pop[g] = rd && fifo_hit && ep_sel == 3'(g) && rx_cnt[g] != 4'h0;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tx_cnt[g] <= 4'h0;
          rx_cnt[g] <= 4'h0;
          tx_wp[g] <= 3'h0;
          tx_rp[g] <= 3'h0;
          rx_wp[g] <= 3'h0;
          rx_rp[g] <= 3'h0;
        end else begin
          tx_cnt[g] <= tx_cnt[g] + {3'h0, tx_push[g]} - {3'h0, tx_pop[g]};
          rx_cnt[g] <= rx_cnt[g] + {3'h0, rx_push[g]} - {3'h0, rx_pop[g]};
          tx_wp[g] <= tx_wp[g] + {2'h0, tx_push[g]};
          tx_rp[g] <= tx_rp[g] + {2'h0, tx_pop[g]};
          rx_wp[g] <= rx_wp[g] + {2'h0, rx_push[g]};
          rx_rp[g] <= rx_rp[g] + {2'h0, rx_pop[g]};
        end
      end

      // Storage needs no reset
      always_ff @(posedge pclk) begin
        if (tx_push[g]) begin
          txm[g][tx_wp[g]] <= pwdata;
        end
        if (rx_push[g]) begin
          rxm[g][rx_wp[g]] <= rx_word.data;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read data and error answer
  // ----------------------------------------------------------------
  // Width consistency per packet is left to software
  always_comb begin
    prdata = `UOE_RST_WORD;
    pslverr = 1'b0;
    if (rd) begin
      if (paddr == `UOE_OFS_STATUS) begin
        prdata = status;
      end else if (paddr == `UOE_OFS_ENABLE) begin
        prdata = enable;
      end else if (paddr == `UOE_OFS_CTRL) begin
        prdata = {31'h0, ctrl_host};
      end else if (fifo_hit) begin
        prdata = rxm[ep_sel][rx_rp[ep_sel]];
        pslverr = rx_cnt[ep_sel] == 4'h0;
      end
    end
    if (acc && !known) begin
      pslverr = 1'b1;
    end
    if (wr && fifo_hit && tx_cnt[ep_sel] == 4'(QD)) begin
      pslverr = 1'b1;
    end
  end

endmodule

/* File: tb/uoe_link_model.sv */
/*
  Model of the far side: cable levels and the packet engine that drains
  the transmit queues. Assumes one pclk; the bench moves the levels.
*/
`timescale 1ns/1ps
module uoe_link_model
  import uoe_pkg::*;
(
  // Clock
  input wire logic pclk,
  // Engine transmit drain
  input wire uoe_word_s tx_word,
  input wire logic tx_valid,
  output logic tx_ready,
  // Cable levels
  output logic vbus_valid,
  output logic session_active,
  output logic srp_seen,
  output logic dev_present,
  output logic suspend_seen
);
  uoe_word_s cap[$];
  initial begin
    {vbus_valid, session_active, srp_seen, dev_present, suspend_seen} = 5'h00;
    tx_ready = 1'b0;
  end
  // Stalls every other cycle so the design must hold its word
  always @(posedge pclk) begin
    if (tx_valid && tx_ready) cap.push_back(tx_word);
    tx_ready <= !tx_ready;
  end
endmodule

/* File: tb/uoe_event_fifo_chk.sv */
/*
  Port checker of the event flag and FIFO port block.
  Assumes it is bound to the top module with zero-wait APB.
*/
`timescale 1ns/1ps
module uoe_event_fifo_chk
  import uoe_pkg::*;
(
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Engine and mode
  input wire uoe_word_s tx_word,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic host_mode,
  input wire logic irq
);
  logic acc;
  logic rd_st;
  logic hole;
  assign acc = psel && penable;
  assign rd_st = acc && !pwrite && paddr == 12'h000;
  assign hole = paddr > 12'h03C || (paddr > 12'h008 && paddr < 12'h020) || paddr[1:0] != 2'h0;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  zero_wait_a: assert property (pready) else $error("pready low");
  idle_bus_a: assert property (!acc |-> prdata == 32'h0 && !pslverr) else $error("idle bus driven");
  hole_err_a: assert property (acc && hole |-> pslverr && prdata == 32'h0) else $error("unmapped taken");
  mode_write_a: assert property (acc && pwrite && paddr == 12'h008 |=> host_mode == $past(pwdata[0]))
    else $error("mode not written");
  mode_read_a: assert property (acc && !pwrite && paddr == 12'h008 |-> prdata == {31'h0, host_mode})
    else $error("mode readback");
  status_bits_a: assert property (rd_st |-> (prdata & 32'hFE0FFFFF) == 32'h0) else $error("status spare");
  irq_cause_a: assert property (rd_st && irq |-> (prdata & 32'h01F00000) != 32'h0)
    else $error("irq without flag");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_word))
    else $error("tx word dropped");
endmodule

/* File: tb/uoe_event_fifo_bench.sv */
/*
  Bench of the event flag and FIFO port block: APB tasks and sequences.
  Assumes a 3-edge event path through the synchroniser; the APB master
  waits for pready however long it takes, and only the watchdog ends a hang.
*/
`timescale 1ns/1ps
module uoe_event_fifo_bench
  import uoe_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rx_valid = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, tx_valid, tx_ready, rx_ready, host_mode, irq, e;
  logic vbus_valid, session_active, srp_seen, dev_present, suspend_seen;
  uoe_word_s tx_word, rx_word = '0;
  int mismatches = 0, comparisons = 0;
  always #4 pclk = !pclk;
  uoe_event_fifo dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .vbus_valid(vbus_valid), .session_active(session_active), .srp_seen(srp_seen),
    .dev_present(dev_present), .suspend_seen(suspend_seen), .tx_word(tx_word), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .host_mode(host_mode), .irq(irq));
  uoe_link_model link(.pclk(pclk), .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .vbus_valid(vbus_valid), .session_active(session_active), .srp_seen(srp_seen),
    .dev_present(dev_present), .suspend_seen(suspend_seen));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input logic [34:0] got, input logic [34:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Whole words only, so one width per packet always holds
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
    chk(e, 1'b0);
  endtask
  task settle;
    repeat (5) @(posedge pclk);
  endtask
  task end_sim;
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, 12'h004, 32'h01F00000);
    rd(12'h004, 32'h01F00000);
    link.srp_seen <= 1'b1;
    settle();
    rd(12'h000, 32'h00400000);
    chk(irq, 1'b1);
    apb(1'b1, 12'h000, 32'h00400000);
    @(posedge pclk);
    chk(irq, 1'b0);
    {link.session_active, link.vbus_valid} <= 2'h3;
    settle();
    link.vbus_valid <= 1'b0;
    settle();
    link.session_active <= 1'b0;
    settle();
    rd(12'h000, 32'h00A00000);
    apb(1'b1, 12'h000, 32'h01F00000);
    apb(1'b1, 12'h008, 32'h1);
    rd(12'h008, 32'h1);
    link.dev_present <= 1'b1;
    settle();
    link.dev_present <= 1'b0;
    settle();
    rd(12'h000, 32'h00300000);
    apb(1'b1, 12'h000, 32'h01F00000);
    apb(1'b1, 12'h004, 32'h00F00000);
    link.suspend_seen <= 1'b1;
    settle();
    chk(irq, 1'b0);
    apb(1'b1, 12'h004, 32'h01000000);
    @(posedge pclk);
    chk(irq, 1'b1);
    apb(1'b1, 12'h02C, 32'hA5A50001);
    apb(1'b1, 12'h02C, 32'hA5A50002);
    repeat (40) @(posedge pclk);
    chk(link.cap.size(), 2);
    chk(link.cap[0], {3'h3, 32'hA5A50001});
    chk(link.cap[1], {3'h3, 32'hA5A50002});
    for (int i = 0; i < 8; i++) begin
      rx_word <= '{ep: 3'h5, data: 32'h100 + i};
      rx_valid <= 1'b1;
      @(posedge pclk);
    end
    rx_valid <= 1'b0;
    @(posedge pclk);
    chk(rx_ready, 1'b0);
    for (int i = 0; i < 8; i++) rd(12'h034, 32'h100 + i);
    apb(1'b0, 12'h034, 32'h0);
    chk(e, 1'b1);
    end_sim();
  end
endmodule
bind uoe_event_fifo uoe_event_fifo_chk chk(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready), .host_mode(host_mode), .irq(irq));
